// ---- inc/tss_pkg.sv ----
// Constants for the two-stream time-slot switch: frame timing, pin sampling
// slots, microport command layout and the assembled-write buffer shape.
// Assumes a system clock well above twice the 4.096 MHz TDM bit clock.
package tss_pkg;

    localparam int unsigned STREAMS   = 2;
    localparam int unsigned ENTRIES   = 64;
    localparam int unsigned ADDR_W    = 6;
    localparam int unsigned CNT_W     = 9;

    // Bit-clock periods counted per frame: channel [8:4], bit [3:1], half [0].
    localparam logic [8:0] CNT_STBUS_LOAD = 9'h000;
    localparam logic [8:0] CNT_GCI_LOAD   = 9'h051;
    localparam logic [8:0] CNT_LAST       = 9'h1FF;
    localparam logic [8:0] CNT_FIRST      = 9'h000;
    localparam logic [4:0] GCI_OUT_CH     = 5'h05;
    localparam logic [2:0] BIT_FIRST      = 3'h0;
    localparam logic [2:0] BIT_LAST       = 3'h7;
    localparam logic [3:0] HALF_FIRST     = 4'h0;
    localparam logic [2:0] FMT_IDLE_RUN   = 3'h5;

    // Synchroniser slots for the asynchronous pins.
    localparam int unsigned PIN_N    = 9;
    localparam int unsigned P_C4     = 0;
    localparam int unsigned P_FS     = 1;
    localparam int unsigned P_TIN0   = 2;
    localparam int unsigned P_TIN1   = 3;
    localparam int unsigned P_RXD    = 4;
    localparam int unsigned P_SCLK   = 5;
    localparam int unsigned P_CS_N   = 6;
    localparam int unsigned P_MPS    = 7;
    localparam int unsigned P_ODE    = 8;

    // Microport command byte: op in [7:6], memory index in [5:0].
    localparam logic [1:0] OP_WR_CM   = 2'h0;
    localparam logic [1:0] OP_WR_MODE = 2'h1;
    localparam logic [1:0] OP_RD_DM   = 2'h2;
    localparam logic [1:0] OP_RD_CM   = 2'h3;
    localparam int unsigned MODE_MSG_BIT = 0;
    localparam int unsigned MODE_TRI_BIT = 1;
    localparam logic [3:0] MP_CMD_LAST  = 4'h7;
    localparam logic [3:0] MP_DATA_LAST = 4'hF;

    localparam int unsigned WORD_W     = 16;
    localparam int unsigned FIFO_DEPTH = 8;

    typedef enum logic [1:0] {
        MP_IDLE  = 2'b00,
        MP_CMD   = 2'b01,
        MP_WDATA = 2'b11,
        MP_RDATA = 2'b10
    } tss_mp_state_t;

endpackage : tss_pkg

// ---- src/tss_fifo.sv ----
// Small synchronous FIFO holding assembled microport write words.
// Assumes DEPTH is a power of two; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
module tss_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk_in,        // System clock.
    input  wire logic             rst_n_in,      // Asynchronous reset, active low.
    input  wire logic             in_valid_in,   // Word offered.
    output logic                  in_ready_out,  // Space available.
    input  wire logic [WIDTH-1:0] in_data_in,    // Offered word.
    output logic                  out_valid_out, // Word available.
    input  wire logic             out_ready_in,  // Consumer takes word.
    output logic [WIDTH-1:0]      out_data_out   // Oldest word.
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               rd;
        logic [AW-1:0]               wr;
        logic [AW:0]                 cnt;
    } tss_fifo_state_t;

    tss_fifo_state_t q;
    tss_fifo_state_t d;
    logic            push;
    logic            pop;

    assign in_ready_out  = (q.cnt != (AW+1)'(DEPTH));
    assign out_valid_out = (q.cnt != '0);
    assign out_data_out  = q.mem[q.rd];

    always_comb begin
        d    = q;
        push = in_valid_in && in_ready_out;
        pop  = out_valid_out && out_ready_in;
        if (push) begin
            d.mem[q.wr] = in_data_in;
            d.wr        = q.wr + 1'b1;
        end
        if (pop) begin
            d.rd = q.rd + 1'b1;
        end
        if (push && !pop) begin
            d.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : tss_fifo

// ---- src/tss_switch.sv ----
// Two-stream time-slot switch: serial TDM in and out, connect and data
// memories, frame pulse conversion, and a serial microport that can turn
// into two control streams. All pins are asynchronous to clk_in and are
// oversampled; clk_in must run well above twice the TDM bit clock.
//
// Behaviour
// - Receive two 2048 kbit/s streams of 32 byte channels, aligned to frame sync.
// - Drive two 2048 kbit/s streams of 32 byte channels, aligned to frame sync.
// - Any of 64 input channels may feed any output channel, non-blocking.
// - Port mode low: sample microport receive data on rising serial clock edges.
// - Port mode high: receive pin is control stream 0 loading connect entries of stream 0.
// - Port mode low: transmit on falling serial clock; port mode high: transmit disabled.
// - Port mode high: serial clock pin is control stream 1 loading stream 1 entries.
// - Normal mode: chip select low enables port; high ignores receive, floats transmit.
// - A 4.096 MHz bit clock shifts all TDM data in and out.
// - Sample each TDM input bit on the rising edge three quarters into the bit.
// - Accept frame sync as low pulse over the boundary or high pulse at slot 5.
// - Output frame pulse in opposite format, shifted five channels.
// - Port mode low selects serial access; high selects control stream mode.
// - Output drive enable low floats both TDM outputs; high lets them drive.
// - With drive enable high, single output channels can be floated by software.
// - Detect sync format from idle level over five clocks; load counter 0 or 5.
// - Low-format output pulse from a high-format input lags by 27 channels.
// - Connection mode sends data memory at connect entry; message mode sends entry.
// - Microport bits travel least significant bit first both ways.
`timescale 1ns/1ps
module tss_switch
    import tss_pkg::*;
(
    input  wire logic clk_in,                     // System clock, 50 MHz.
    input  wire logic rst_n_in,                   // Asynchronous reset, active low.
    input  wire logic tdm_bit_clock_in,           // 4.096 MHz TDM bit clock pin.
    input  wire logic frame_sync_in,              // Frame sync pin, either format.
    input  wire logic tdm_in_0_in,                // Serial TDM input 0.
    input  wire logic tdm_in_1_in,                // Serial TDM input 1.
    output logic      tdm_out_0_out,              // Serial TDM output 0 data.
    output logic      tdm_out_0_oe_out,           // Output 0 drive enable.
    output logic      tdm_out_1_out,              // Serial TDM output 1 data.
    output logic      tdm_out_1_oe_out,           // Output 1 drive enable.
    output logic      frame_sync_out,             // Converted frame pulse.
    input  wire logic port_mode_select_in,        // High selects control streams.
    input  wire logic output_drive_enable_in,     // Low floats both TDM outputs.
    input  wire logic rxd_control_stream_in_0_in, // Microport data or control stream 0.
    input  wire logic sclk_control_stream_in_1_in,// Microport clock or control stream 1.
    input  wire logic cs_n_in,                    // Microport select, active low.
    output logic      txd_out,                    // Microport transmit data.
    output logic      txd_oe_out                  // Microport transmit drive enable.
);

    typedef struct packed {
        logic [PIN_N-1:0]              s1;
        logic [PIN_N-1:0]              s2;
        logic                          c4_p;
        logic                          fs_lvl;
        logic [2:0]                    fs_run;
        logic                          fmt_gci;
        logic                          fs_act_p;
        logic                          fs_hit;
        logic [CNT_W-1:0]              cnt;
        logic [STREAMS-1:0][7:0]       in_sr;
        logic [STREAMS-1:0][7:0]       cs_sr;
        logic [STREAMS-1:0][7:0]       out_sr;
        logic [STREAMS-1:0]            ch_oe;
        logic [STREAMS-1:0]            out_oe;
        logic                          fso;
        logic [ENTRIES-1:0][7:0]       dm;
        logic [ENTRIES-1:0][7:0]       cm;
        logic [ENTRIES-1:0]            msg;
        logic [ENTRIES-1:0]            tri_en;
        tss_mp_state_t                 mp_st;
        logic                          sclk_p;
        logic [3:0]                    mp_cnt;
        logic [7:0]                    mp_sr;
        logic [7:0]                    mp_cmd;
        logic [7:0]                    tx_sr;
        logic                          txd;
        logic                          tx_oe;
        logic                          wr_pend;
        logic [WORD_W-1:0]             wr_word;
    } tss_state_t;

    tss_state_t        q;
    tss_state_t        d;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic              fifo_out_ready;
    logic [WORD_W-1:0] fifo_out_data;

    // Control-stream writes own the connect memory in their cycle.
    logic              cst_wr;
    logic              c4;
    logic              fs;
    logic              fs_act;
    logic              port_mode_select;
    logic              output_drive_enable;
    logic              sclk;
    logic              rxd;
    logic              cs_n;
    logic [CNT_W-1:0]  ncnt;
    logic [STREAMS-1:0] tin;
    logic [7:0]        byte_in;
    logic [7:0]        cs_byte;
    logic [ADDR_W-1:0] idx;
    logic [ADDR_W-1:0] fifo_addr;
    logic [7:0]        mp_byte;

    always_comb begin
        d         = q;
        cst_wr    = 1'b0;
        ncnt      = q.cnt;
        byte_in   = '0;
        cs_byte   = '0;
        idx       = '0;
        mp_byte   = '0;
        d.s1      = {output_drive_enable_in, port_mode_select_in, cs_n_in,
                     sclk_control_stream_in_1_in, rxd_control_stream_in_0_in,
                     tdm_in_1_in, tdm_in_0_in, frame_sync_in, tdm_bit_clock_in};
        d.s2      = q.s1;
        c4        = q.s2[P_C4];
        fs        = q.s2[P_FS];
        port_mode_select       = q.s2[P_MPS];
        output_drive_enable       = q.s2[P_ODE];
        sclk      = q.s2[P_SCLK];
        rxd       = q.s2[P_RXD];
        cs_n      = q.s2[P_CS_N];
        tin       = {q.s2[P_TIN1], q.s2[P_TIN0]};
        fs_act    = q.fmt_gci ? fs : ~fs;
        d.c4_p    = c4;

        if (c4 && !q.c4_p) begin
            d.fs_act_p = fs_act;
            if (fs_act && !q.fs_act_p) begin
                d.fs_hit = 1'b1;
            end
            if (q.cnt[0]) begin
                for (int s = 0; s < STREAMS; s++) begin
                    byte_in    = {q.in_sr[s][6:0], tin[s]};
                    d.in_sr[s] = byte_in;
                    // Control stream sampling.
                    // A shift register of its own keeps the data memory filling in stream mode.
                    cs_byte    = {q.cs_sr[s][6:0], (s == 0) ? rxd : sclk};
                    d.cs_sr[s] = cs_byte;
                    if (q.cnt[3:1] == BIT_LAST) begin
                        idx = {1'(s), q.cnt[8:4]};
                        d.dm[idx] = byte_in;
                        if (port_mode_select) begin
                            d.cm[idx] = cs_byte;
                            cst_wr    = 1'b1;
                        end
                    end
                end
            end
        end

        // Bit clock falling edge.
        if (!c4 && q.c4_p) begin
            if (fs == q.fs_lvl) begin
                if (q.fs_run != FMT_IDLE_RUN) begin
                    d.fs_run = q.fs_run + 1'b1;
                end else begin
                    d.fmt_gci = ~fs;
                end
            end else begin
                d.fs_lvl = fs;
                d.fs_run = 3'h1;
            end
            if (q.fs_hit) begin
                ncnt     = q.fmt_gci ? CNT_GCI_LOAD : CNT_STBUS_LOAD;
                d.fs_hit = 1'b0;
            end else begin
                ncnt = q.cnt + 1'b1;
            end
            d.cnt = ncnt;
            if (!ncnt[0]) begin
                for (int s = 0; s < STREAMS; s++) begin
                    d.out_sr[s] = {q.out_sr[s][6:0], 1'b0};
                    if (ncnt[3:0] == HALF_FIRST) begin
                        idx = {1'(s), ncnt[8:4]};
                        if (q.msg[idx]) begin
                            d.out_sr[s] = q.cm[idx];
                        end else begin
                            d.out_sr[s] = q.dm[q.cm[idx][ADDR_W-1:0]];
                        end
                        d.ch_oe[s] = ~(q.tri_en[idx] & ~q.msg[idx]);
                    end
                end
            end
            if (q.fmt_gci) begin
                d.fso = ~((ncnt == CNT_LAST) || (ncnt == CNT_FIRST));
            end else begin
                d.fso = (ncnt[8:4] == GCI_OUT_CH) && (ncnt[3:1] == BIT_FIRST);
            end
        end

        for (int s = 0; s < STREAMS; s++) begin
            d.out_oe[s] = output_drive_enable & d.ch_oe[s];
        end

        // The clear comes first so that a word completing in the same cycle stays pending.
        if (q.wr_pend && fifo_in_ready) begin
            d.wr_pend = 1'b0;
        end

        // Microport in normal mode.
        d.sclk_p = sclk;
        if (port_mode_select || cs_n) begin
            d.mp_st  = MP_IDLE;
            d.mp_cnt = '0;
            d.tx_oe  = 1'b0;
        end else begin
            unique case (q.mp_st)
                MP_IDLE: begin
                    d.mp_st  = MP_CMD;
                    d.mp_cnt = '0;
                end
                MP_CMD, MP_WDATA: begin
                    if (sclk && !q.sclk_p) begin
                        mp_byte  = {rxd, q.mp_sr[7:1]};
                        d.mp_sr  = mp_byte;
                        d.mp_cnt = q.mp_cnt + 1'b1;
                        if (q.mp_st == MP_CMD && q.mp_cnt == MP_CMD_LAST) begin
                            d.mp_cmd = mp_byte;
                            idx      = mp_byte[ADDR_W-1:0];
                            if (mp_byte[7:6] == OP_RD_DM) begin
                                d.tx_sr = q.dm[idx];
                                d.mp_st = MP_RDATA;
                            end else if (mp_byte[7:6] == OP_RD_CM) begin
                                d.tx_sr = q.cm[idx];
                                d.mp_st = MP_RDATA;
                            end else begin
                                d.mp_st = MP_WDATA;
                            end
                        end
                        if (q.mp_st == MP_WDATA && q.mp_cnt == MP_DATA_LAST) begin
                            d.wr_pend = 1'b1;
                            d.wr_word = {q.mp_cmd, mp_byte};
                            d.mp_st   = MP_CMD;
                        end
                    end
                end
                MP_RDATA: begin
                    if (!sclk && q.sclk_p) begin
                        d.tx_oe = 1'b1;
                        d.txd   = q.tx_sr[0];
                        d.tx_sr = {1'b0, q.tx_sr[7:1]};
                    end
                end
            endcase
        end

        // Drain buffered writes into the connect memory.
        fifo_out_ready = ~cst_wr;
        fifo_addr      = fifo_out_data[8 +: ADDR_W];
        if (fifo_out_valid && fifo_out_ready) begin
            unique case (fifo_out_data[15:14])
                OP_WR_CM: begin
                    d.cm[fifo_addr] = fifo_out_data[7:0];
                end
                OP_WR_MODE: begin
                    d.msg[fifo_addr]    = fifo_out_data[MODE_MSG_BIT];
                    d.tri_en[fifo_addr] = fifo_out_data[MODE_TRI_BIT];
                end
                OP_RD_DM, OP_RD_CM: begin
                    d.msg[fifo_addr] = q.msg[fifo_addr];
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Back-pressure holds the assembled word until the buffer has room.
    tss_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (q.wr_pend),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (q.wr_word),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_out_ready),
        .out_data_out  (fifo_out_data)
    );

    assign tdm_out_0_out    = q.out_sr[0][7];
    assign tdm_out_1_out    = q.out_sr[1][7];
    assign tdm_out_0_oe_out = q.out_oe[0];
    assign tdm_out_1_oe_out = q.out_oe[1];
    assign frame_sync_out   = q.fso;
    assign txd_out          = q.txd;
    assign txd_oe_out       = q.tx_oe;

endmodule : tss_switch

// ---- tb/test_tss_switch.sv ----
// Bench for tss_switch: random connections over the microport, control
// streams, both sync formats. Assumes tss_tdm_peer drives the TDM side.
`timescale 1ns/1ps
module test_tss_switch;
    import tss_pkg::*;
    logic       clk_in, rst_n_in, drv_en, pmode, cs_n, urx, uclk, gci;
    logic       bclk, fs, t0, t1, t0e, t1e, fso, txd, txde, fsa, fsb, fsc;
    logic [3:0] sd;
    logic [8:0] cnt;
    logic [7:0] cm [64];
    logic [1:0] md [64];
    logic [7:0] got [64];
    logic       gote [64];
    logic [7:0] sr0, sr1;
    int         errors, compares, seed, cycles;

    tss_switch tss_switch_i (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .tdm_bit_clock_in(bclk),
        .frame_sync_in(fs), .tdm_in_0_in(sd[0]), .tdm_in_1_in(sd[1]),
        .tdm_out_0_out(t0), .tdm_out_0_oe_out(t0e), .tdm_out_1_out(t1),
        .tdm_out_1_oe_out(t1e), .frame_sync_out(fso), .port_mode_select_in(pmode),
        .output_drive_enable_in(drv_en), .rxd_control_stream_in_0_in(pmode ? sd[2] : urx),
        .sclk_control_stream_in_1_in(pmode ? sd[3] : uclk), .cs_n_in(cs_n),
        .txd_out(txd), .txd_oe_out(txde));
    tss_tdm_peer tss_tdm_peer_i (
        .gci_in(gci), .bclk_out(bclk), .fs_out(fs), .sd_out(sd), .cnt_out(cnt));

    always #10 clk_in = ~clk_in;

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 95000) begin
            errors++;
            test_done();
        end
    end

    // Late in each bit cell, well clear of the output update.
    always @(posedge bclk) begin
        if (cnt[0]) begin
            sr0 = {sr0[6:0], t0};
            sr1 = {sr1[6:0], t1};
            if (cnt[3:1] == 3'h7) begin
                got[cnt[8:4]] = sr0;
                got[cnt[8:4] + 32] = sr1;
                gote[cnt[8:4]] = t0e;
                gote[cnt[8:4] + 32] = t1e;
            end
        end
        if (cnt == 9'h051) fsa = fso;
        if (cnt == 9'h000) fsb = fso;
        if (cnt == 9'h100) fsc = fso;
    end

    function automatic logic [7:0] pat(input int s, input int c);
        return 8'(c * 37 + s * 77) ^ 8'hA5;
    endfunction : pat

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    task automatic frames(input int n);
        repeat (n) @(posedge bclk iff (cnt == 9'h1FF));
        @(posedge clk_in);
        #1;
    endtask : frames

    task automatic half();
        repeat (4) @(posedge clk_in);
        #1;
    endtask : half

    task automatic ubyte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            uclk = 1'b0;
            urx = b[i];
            half();
            uclk = 1'b1;
            half();
        end
    endtask : ubyte

    task automatic uread(input logic [1:0] op, input logic [5:0] idx, input logic [7:0] e);
        logic [7:0] v;
        cs_n = 1'b0;
        half();
        ubyte({op, idx});
        for (int i = 0; i < 8; i++) begin
            uclk = 1'b0;
            urx = ~urx;
            half();
            uclk = 1'b1;
            v[i] = txd;
            check("txd_oe", txde, 1'b1);
            half();
        end
        check("read", v, e);
        cs_n = 1'b1;
        half();
        check("txd_oe", txde, 1'b0);
    endtask : uread

    task automatic check_out();
        logic [7:0] e;
        for (int i = 0; i < 64; i++) begin
            e = md[i][0] ? cm[i] : pat(cm[i][5], cm[i][4:0]);
            check("oe", gote[i], drv_en && md[i] != 2'h2);
            if (drv_en && md[i] != 2'h2)
                check("data", got[i], e);
        end
    endtask : check_out

    initial begin
        {clk_in, rst_n_in, pmode, urx, gci, cycles, errors, compares} = '0;
        {drv_en, cs_n, uclk} = 3'h7;
        seed = 32'h92C42FBB;
        foreach (cm[i]) {cm[i], md[i]} = 10'h000;
        repeat (3) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        frames(3);
        check_out();
        check("pulse", fsa, 1'b1);
        check("idle", fsc, 1'b0);
        $display("test reset done");
        cs_n = 1'b0;
        half();
        for (int i = 0; i < 64; i++) begin
            cm[i] = 8'($random(seed));
            md[i] = 2'($random(seed));
            ubyte({OP_WR_CM, 6'(i)});
            ubyte(cm[i]);
            ubyte({OP_WR_MODE, 6'(i)});
            ubyte({6'h00, md[i]});
        end
        cs_n = 1'b1;
        urx = ~urx;
        frames(2);
        check_out();
        for (int i = 0; i < 64; i += 9) begin
            uread(OP_RD_CM, 6'(i), cm[i]);
            uread(OP_RD_DM, 6'(i), pat(i / 32, i % 32));
        end
        $display("test microport done");
        drv_en = 1'b0;
        frames(2);
        check_out();
        drv_en = 1'b1;
        $display("test drive enable done");
        pmode = 1'b1;
        cs_n = 1'b0;
        frames(3);
        foreach (cm[i]) cm[i] = pat(2 + i / 32, i % 32);
        check_out();
        check("txd_oe", txde, 1'b0);
        pmode = 1'b0;
        cs_n = 1'b1;
        $display("test control stream done");
        gci = 1'b1;
        frames(4);
        check("pulse", fsb, 1'b0);
        check("idle", fsc, 1'b1);
        check_out();
        $display("test high pulse sync done");
        test_done();
    end
endmodule : test_tss_switch

// ---- tb/tss_switch_monitor.sv ----
// Pin timing checker for tss_switch, bound to the top module.
// Assumes every pin holds for several clk_in cycles per phase.
`timescale 1ns/1ps
module tss_switch_monitor (
    input wire logic clk_in,                      // System clock.
    input wire logic rst_n_in,                    // Reset, active low.
    input wire logic tdm_bit_clock_in,            // Bit clock pin.
    input wire logic output_drive_enable_in,      // Drive enable pin.
    input wire logic port_mode_select_in,         // Port mode pin.
    input wire logic sclk_control_stream_in_1_in, // Serial clock pin.
    input wire logic cs_n_in,                     // Select pin, active low.
    input wire logic tdm_out_0_out,               // Output 0 data.
    input wire logic tdm_out_0_oe_out,            // Output 0 enable.
    input wire logic tdm_out_1_oe_out,            // Output 1 enable.
    input wire logic frame_sync_out,              // Frame pulse out.
    input wire logic txd_out,                     // Transmit data.
    input wire logic txd_oe_out                   // Transmit enable.
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_drive_off_floats :
        assert property (!output_drive_enable_in [*5] |-> !tdm_out_0_oe_out && !tdm_out_1_oe_out)
        else $error("outputs driven while drive enable low");
    a_stream_mode_txd :
        assert property (port_mode_select_in [*5] |-> !txd_oe_out)
        else $error("transmit driven in control stream mode");
    a_deselect_txd :
        assert property (cs_n_in [*5] |-> !txd_oe_out)
        else $error("transmit driven while deselected");
    a_txd_on_fall :
        assert property (txd_oe_out && $changed(txd_out) |-> !$past(sclk_control_stream_in_1_in, 2))
        else $error("transmit bit changed off a falling serial clock");
    a_tdm_on_fall :
        assert property ($changed(tdm_out_0_out) |-> !$past(tdm_bit_clock_in, 2))
        else $error("output bit changed off a falling bit clock");
    a_pulse_on_fall :
        assert property ($changed(frame_sync_out) |-> !$past(tdm_bit_clock_in, 2))
        else $error("frame pulse changed off a falling bit clock");
    a_high_pulse_width :
        assert property ($rose(frame_sync_out) |=> frame_sync_out [*8])
        else $error("frame pulse high too short");
    a_low_pulse_width :
        assert property ($fell(frame_sync_out) |=> !frame_sync_out [*8])
        else $error("frame pulse low too short");
    a_float_at_slot :
        assert property ($changed(tdm_out_1_oe_out) && output_drive_enable_in
            && $past(output_drive_enable_in, 6) |-> !$past(tdm_bit_clock_in, 2))
        else $error("channel enable changed off a slot edge");
endmodule : tss_switch_monitor

bind tss_switch tss_switch_monitor tss_switch_monitor_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .tdm_bit_clock_in(tdm_bit_clock_in),
    .output_drive_enable_in(output_drive_enable_in), .port_mode_select_in(port_mode_select_in),
    .sclk_control_stream_in_1_in(sclk_control_stream_in_1_in), .cs_n_in(cs_n_in),
    .tdm_out_0_out(tdm_out_0_out), .tdm_out_0_oe_out(tdm_out_0_oe_out),
    .tdm_out_1_oe_out(tdm_out_1_oe_out), .frame_sync_out(frame_sync_out),
    .txd_out(txd_out), .txd_oe_out(txd_oe_out));

// ---- tb/tss_tdm_peer.sv ----
// TDM peer: free bit clock, frame sync in either format, four streams.
// Assumes the bench reads cnt_out to align its own sampling.
`timescale 1ns/1ps
module tss_tdm_peer (
    input  wire logic gci_in,         // High selects the high-pulse sync.
    output logic       bclk_out,      // Bit clock, runs free.
    output logic       fs_out,        // Frame sync.
    output logic [3:0] sd_out,        // Streams 0 to 3.
    output logic [8:0] cnt_out        // Half-bit count within the frame.
);
    logic [7:0] b;

    initial begin
        bclk_out = 1'b1;
        fs_out = 1'b1;
        sd_out = 4'h0;
        cnt_out = 9'h000;
        #7;
        forever #80 bclk_out = ~bclk_out;
    end

    always @(negedge bclk_out) begin
        cnt_out = cnt_out + 9'h001;
        fs_out = gci_in ? (cnt_out == 9'h050) : (cnt_out != 9'h1FF);
        for (int s = 0; s < 4; s++) begin
            b = 8'(cnt_out[8:4] * 37 + s * 77) ^ 8'hA5;
            if (!cnt_out[0])
                sd_out[s] = b[3'h7 - cnt_out[3:1]];
        end
    end
endmodule : tss_tdm_peer
